// file: core/rtcus_i2c_slave.sv
`timescale 1ns/1ps
module rtcus_i2c_slave
  import rtcus_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Register side
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK
  } rtcus_i2c_state_t;

  rtcus_i2c_state_t state_reg;
  logic scl_reg;
  logic sda_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic rw_reg;
  logic ptr_loaded_reg;
  logic nack_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // Edge and bus condition detect
  assign scl_rise = i_scl & ~scl_reg;
  assign scl_fall = ~i_scl & scl_reg;
  assign start_cond = i_scl & scl_reg & sda_reg & ~i_sda;
  assign stop_cond = i_scl & scl_reg & ~sda_reg & i_sda;
  assign o_sda_out = 1'b0; // Open drain: only ever pulls low

  // Previous pin levels
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= i_scl;
      sda_reg <= i_sda;
    end
  end

  // Byte engine; pointer auto-increments after every data byte
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      ptr_loaded_reg <= 1'b0;
      nack_reg <= 1'b0;
      o_sda_oe <= 1'b0;
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      o_addr <= 8'h00;
      o_wdata <= 8'h00;
    end else begin
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      if (start_cond) begin
        state_reg <= ST_ADDR;
        cnt_reg <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise && cnt_reg < 4'h8) begin
              shift_reg <= {shift_reg[6:0], i_sda};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == I2C_SLAVE_ADDR) begin
                  rw_reg <= shift_reg[0];
                  ptr_loaded_reg <= 1'b0;
                  o_sda_oe <= 1'b1;
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                o_sda_oe <= 1'b1;
                state_reg <= ST_ACK;
                if (!ptr_loaded_reg) begin
                  o_addr <= shift_reg;
                  ptr_loaded_reg <= 1'b1;
                end else begin
                  o_wdata <= shift_reg;
                  o_wr_stb <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                // Load first read byte, strobe marks the read
                shift_reg <= i_rdata;
                o_sda_oe <= ~i_rdata[7];
                o_rd_stb <= 1'b1;
                state_reg <= ST_READ;
              end else begin
                o_sda_oe <= 1'b0;
                state_reg <= ST_WRITE;
              end
            end else if (o_wr_stb) begin
              o_addr <= o_addr + 8'h01;
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (cnt_reg < 4'h8) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                o_sda_oe <= ~shift_reg[6];
              end else begin
                o_sda_oe <= 1'b0;
                o_addr <= o_addr + 8'h01;
                state_reg <= ST_RACK;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_reg <= i_sda;
            end else if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                shift_reg <= i_rdata;
                o_sda_oe <= ~i_rdata[7];
                o_rd_stb <= 1'b1;
                state_reg <= ST_READ;
              end
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// file: core/rtcus_top.sv
`timescale 1ns/1ps
// Function
// - After commit request, set write-done flag when buffered data reaches counters.
// - After snapshot request, set snapshot-done flag when counters reach read buffers.
// - Clear-on-read set clears both done flags on status read; else host writes zero.
// - Threshold code in bits 3:2 selects 0.5, 1.0, 1.5 or 2.0 seconds.
// - Bit 7 enables momentary power-loss restart; resets disabled.
// - Seconds writes sit in a buffer until a commit request moves them.
// - Seconds read value changes only when a snapshot request copies the counter.
// - Binary seconds run 0 to 59 and roll over after 59.
// - BCD seconds hold tens 0 to 5 in 6:4, units 0 to 9 in 3:0.
// - Commit request bit self-clears once the transfer completes.
// - Snapshot request bit self-clears once the copy completes.
// - Clear-on-read control bit resets to one.
// - Data-mode bit picks binary (0) or BCD (1) for the seconds.
module rtcus_top
  import rtcus_pkg::*;
#(
  parameter int TRANSFER_CYCLES_P = TRANSFER_CYCLES,
  parameter int SECOND_CYCLES_P = SECOND_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Two-wire host bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Power-loss restart settings for the detector
  output logic o_power_loss_restart_enable,
  output logic [11:0] o_power_loss_threshold_ms
);
  logic wr_stb;
  logic rd_stb;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] rdata;

  logic [7:0] time_ctrl_reg;
  logic [7:0] update_ctrl_reg;
  logic write_done_flag_reg;
  logic read_snapshot_done_flag_reg;
  logic [7:0] power_loss_config_reg;
  logic [6:0] sec_wbuf_reg;
  logic [6:0] sec_rbuf_reg;
  logic [6:0] sec_count_reg;
  logic [20:0] commit_cnt_reg;
  logic [20:0] snap_cnt_reg;
  logic [26:0] tick_cnt_reg;
  logic tick;
  logic commit_done;
  logic snap_done;
  logic bcd_mode;
  logic wr_update_ctrl;
  logic status_read;

  // Next seconds value, rolling over after 59 in either encoding
  function automatic logic [6:0] sec_increment(input logic [6:0] v, input logic bcd);
    logic [6:0] r;
    r = 7'h00;
    if (bcd) begin
      if (v[3:0] >= SEC_UNITS_MAX) begin
        r = (v[6:4] >= SEC_TENS_MAX) ? 7'h00 : {v[6:4] + 3'h1, 4'h0};
      end else begin
        r = {v[6:4], v[3:0] + 4'h1};
      end
    end else begin
      r = (v >= SEC_BIN_MAX) ? 7'h00 : v + 7'h01;
    end
    return r;
  endfunction

  // Out-of-range values are forced to zero rather than counting wild
  function automatic logic [6:0] sec_sanitize(input logic [6:0] v, input logic bcd);
    logic ok;
    ok = bcd ? (v[6:4] <= SEC_TENS_MAX && v[3:0] <= SEC_UNITS_MAX) : (v <= SEC_BIN_MAX);
    return ok ? v : 7'h00;
  endfunction

  rtcus_i2c_slave u_i2c (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_wr_stb(wr_stb),
    .o_rd_stb(rd_stb),
    .o_addr(bus_addr),
    .o_wdata(bus_wdata),
    .i_rdata(rdata)
  );

  assign bcd_mode = time_ctrl_reg[BIT_DATA_MODE_BCD];
  assign wr_update_ctrl = wr_stb && bus_addr == ADDR_UPDATE_CTRL;
  assign status_read = rd_stb && bus_addr == ADDR_UPDATE_FLAGS;
  assign commit_done = update_ctrl_reg[BIT_WRITE_COMMIT_REQUEST]
      && commit_cnt_reg == 21'(TRANSFER_CYCLES_P - 1);
  assign snap_done = update_ctrl_reg[BIT_READ_SNAPSHOT_REQUEST]
      && snap_cnt_reg == 21'(TRANSFER_CYCLES_P - 1);
  assign tick = tick_cnt_reg == 27'(SECOND_CYCLES_P - 1);

  // Read mux; reserved bits read zero
  always_comb begin
    case (bus_addr)
      ADDR_TIME_CTRL: rdata = time_ctrl_reg & MASK_TIME_CTRL;
      ADDR_UPDATE_CTRL: rdata = update_ctrl_reg & MASK_UPDATE_CTRL;
      ADDR_UPDATE_FLAGS: rdata = {6'h00, read_snapshot_done_flag_reg, write_done_flag_reg};
      ADDR_POWER_LOSS_CONFIG: rdata = power_loss_config_reg & MASK_POWER_LOSS_CONFIG;
      ADDR_MINUTE_FRACTION_COUNT: rdata = {1'b0, sec_rbuf_reg};
      default: rdata = 8'h00;
    endcase
  end

  // Time control and power-loss config
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      time_ctrl_reg <= RESET_TIME_CTRL;
      power_loss_config_reg <= RESET_POWER_LOSS_CONFIG;
    end else if (wr_stb) begin
      if (bus_addr == ADDR_TIME_CTRL) begin
        time_ctrl_reg <= bus_wdata & MASK_TIME_CTRL;
      end
      if (bus_addr == ADDR_POWER_LOSS_CONFIG) begin
        power_loss_config_reg <= bus_wdata & MASK_POWER_LOSS_CONFIG;
      end
    end
  end

  // Power-loss settings out; threshold is (code + 1) half-seconds
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_power_loss_restart_enable <= 1'b0;
      o_power_loss_threshold_ms <= THRESHOLD_MS_STEP;
    end else begin
      o_power_loss_restart_enable <= power_loss_config_reg[BIT_POWER_LOSS_RESTART_ENABLE];
      o_power_loss_threshold_ms <= THRESHOLD_MS_STEP * 12'({10'h000,
          power_loss_config_reg[BIT_THRESHOLD_HI:BIT_THRESHOLD_LO]} + 12'h001);
    end
  end

  // Update control; request bits self-clear, a new request in the same cycle wins
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      update_ctrl_reg <= RESET_UPDATE_CTRL;
    end else if (wr_update_ctrl) begin
      update_ctrl_reg <= bus_wdata & MASK_UPDATE_CTRL;
    end else begin
      if (commit_done) begin
        update_ctrl_reg[BIT_WRITE_COMMIT_REQUEST] <= 1'b0;
      end
      if (snap_done) begin
        update_ctrl_reg[BIT_READ_SNAPSHOT_REQUEST] <= 1'b0;
      end
    end
  end

  // Transfer delay counters, restarted whenever a request is idle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      commit_cnt_reg <= 21'h000000;
      snap_cnt_reg <= 21'h000000;
    end else begin
      if (!update_ctrl_reg[BIT_WRITE_COMMIT_REQUEST] || commit_done) begin
        commit_cnt_reg <= 21'h000000;
      end else begin
        commit_cnt_reg <= commit_cnt_reg + 21'h000001;
      end
      if (!update_ctrl_reg[BIT_READ_SNAPSHOT_REQUEST] || snap_done) begin
        snap_cnt_reg <= 21'h000000;
      end else begin
        snap_cnt_reg <= snap_cnt_reg + 21'h000001;
      end
    end
  end

  // Done flags: hardware set beats read or write clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      write_done_flag_reg <= RESET_UPDATE_FLAGS[BIT_WRITE_DONE_FLAG];
      read_snapshot_done_flag_reg <= RESET_UPDATE_FLAGS[BIT_READ_SNAPSHOT_DONE_FLAG];
    end else begin
      if (commit_done) begin
        write_done_flag_reg <= 1'b1;
      end else if (status_read && update_ctrl_reg[BIT_FLAG_CLEAR_ON_READ]) begin
        write_done_flag_reg <= 1'b0;
      end else if (wr_stb && bus_addr == ADDR_UPDATE_FLAGS
          && !update_ctrl_reg[BIT_FLAG_CLEAR_ON_READ] && !bus_wdata[BIT_WRITE_DONE_FLAG]) begin
        write_done_flag_reg <= 1'b0;
      end
      if (snap_done) begin
        read_snapshot_done_flag_reg <= 1'b1;
      end else if (status_read && update_ctrl_reg[BIT_FLAG_CLEAR_ON_READ]) begin
        read_snapshot_done_flag_reg <= 1'b0;
      end else if (wr_stb && bus_addr == ADDR_UPDATE_FLAGS
          && !update_ctrl_reg[BIT_FLAG_CLEAR_ON_READ]
          && !bus_wdata[BIT_READ_SNAPSHOT_DONE_FLAG]) begin
        read_snapshot_done_flag_reg <= 1'b0;
      end
    end
  end

  // One-second enable from the master clock
  always_ff @(posedge i_mclk) begin
    if (i_rst || tick) begin
      tick_cnt_reg <= 27'h0000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 27'h0000001;
    end
  end

  // Seconds buffers and counter; commit overrides a tick in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sec_wbuf_reg <= RESET_SECONDS[6:0];
      sec_rbuf_reg <= RESET_SECONDS[6:0];
      sec_count_reg <= RESET_SECONDS[6:0];
    end else begin
      if (wr_stb && bus_addr == ADDR_MINUTE_FRACTION_COUNT) begin
        sec_wbuf_reg <= bus_wdata[6:0] & MASK_SECONDS[6:0];
      end
      if (commit_done) begin
        sec_count_reg <= sec_sanitize(sec_wbuf_reg, bcd_mode);
      end else if (tick && !update_ctrl_reg[BIT_FREEZE_SECONDS]) begin
        sec_count_reg <= sec_increment(sec_count_reg, bcd_mode);
      end
      if (snap_done) begin
        sec_rbuf_reg <= sec_count_reg;
      end
    end
  end
endmodule

// file: shared/rtcus_pkg.sv
package rtcus_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_TIME_CTRL = 8'h03;
  localparam logic [7:0] ADDR_UPDATE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_UPDATE_FLAGS = 8'h05;
  localparam logic [7:0] ADDR_POWER_LOSS_CONFIG = 8'h06;
  localparam logic [7:0] ADDR_MINUTE_FRACTION_COUNT = 8'h07;
  // Time control fields
  localparam int BIT_DATA_MODE_BCD = 0;
  localparam int BIT_HOUR_FORMAT = 1;
  // Update control fields
  localparam int BIT_WRITE_COMMIT_REQUEST = 0;
  localparam int BIT_FLAG_CLEAR_ON_READ = 1;
  localparam int BIT_FREEZE_SECONDS = 2;
  localparam int BIT_READ_SNAPSHOT_REQUEST = 4;
  // Update flag fields
  localparam int BIT_WRITE_DONE_FLAG = 0;
  localparam int BIT_READ_SNAPSHOT_DONE_FLAG = 1;
  // Power-loss config fields
  localparam int BIT_THRESHOLD_LO = 2;
  localparam int BIT_THRESHOLD_HI = 3;
  localparam int BIT_POWER_LOSS_RESTART_ENABLE = 7;
  // Reset values
  localparam logic [7:0] RESET_TIME_CTRL = 8'h00;
  localparam logic [7:0] RESET_UPDATE_CTRL = 8'h02;
  localparam logic [7:0] RESET_UPDATE_FLAGS = 8'h00;
  localparam logic [7:0] RESET_POWER_LOSS_CONFIG = 8'h00;
  localparam logic [7:0] RESET_SECONDS = 8'h00;
  // Writable masks, reserved bits excluded
  localparam logic [7:0] MASK_TIME_CTRL = 8'h03;
  localparam logic [7:0] MASK_UPDATE_CTRL = 8'h17;
  localparam logic [7:0] MASK_POWER_LOSS_CONFIG = 8'h8c;
  localparam logic [7:0] MASK_SECONDS = 8'h7f;
  // Seconds encoding limits
  localparam logic [6:0] SEC_BIN_MAX = 7'h3b;
  localparam logic [3:0] SEC_UNITS_MAX = 4'h9;
  localparam logic [2:0] SEC_TENS_MAX = 3'h5;
  // Power-loss threshold per code, in milliseconds
  localparam logic [11:0] THRESHOLD_MS_STEP = 12'h1f4;
  // Timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int TRANSFER_TIME_US = 15_000;
  localparam int TRANSFER_CYCLES = TRANSFER_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SECOND_TIME_MS = 1_000;
  localparam int SECOND_CYCLES = SECOND_TIME_MS * (CLK_FREQ_HZ / 1_000);
  // Bus
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h68;
endpackage

// file: sim/rtcus_host.sv
`timescale 1ns/1ps
// Behavioural two-wire master standing in for host software
module rtcus_host (
  // Clock and wire level
  input wire logic i_mclk,
  input wire logic i_sda,
  // Bus drive: clock driven both ways, data low pull only
  output logic o_scl,
  output logic o_sda_low
);
  int nacks;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    nacks = 0;
  end
  // Five cycles a phase keeps margin over the four-cycle minimum
  task automatic ph();
    repeat (5) @(posedge i_mclk);
    #1;
  endtask
  task automatic bit_o(input logic b);
    o_sda_low = !b;
    ph();
    o_scl = 1'b1;
    ph();
    o_scl = 1'b0;
  endtask
  task automatic bit_i(output logic b);
    o_sda_low = 1'b0;
    ph();
    o_scl = 1'b1;
    ph();
    b = i_sda;
    o_scl = 1'b0;
  endtask
  // Works from idle or from a low clock, so also as repeated start
  task automatic start();
    o_sda_low = 1'b0;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda_low = 1'b1;
    ph();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda_low = 1'b0;
    ph();
  endtask
  task automatic byte_o(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_o(d[i]);
    end
    bit_i(a);
    if (a) nacks++;
  endtask
  // Master answers with a nack, ending the read
  task automatic byte_i(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_i(d[i]);
    end
    bit_o(1'b1);
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d);
    start();
    byte_o(dev);
    byte_o(a);
    byte_o(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    byte_o(8'hd0);
    byte_o(a);
    start();
    byte_o(8'hd1);
    byte_i(d);
    stop();
  endtask
endmodule

// file: sim/rtcus_top_checker.sv
`timescale 1ns/1ps
// Port-level watch on the bus pin and the power-loss settings
module rtcus_top_checker (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // Settings
  input wire logic o_power_loss_restart_enable,
  input wire logic [11:0] o_power_loss_threshold_ms
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Open drain, so the driven level never goes high
  a_sda_level_low: assert property (o_sda_out == 1'b0)
    else $error("sda drive level not low");
  // Only the four coded thresholds may appear
  a_thr_code_legal: assert property (o_power_loss_threshold_ms inside
    {12'h1f4, 12'h3e8, 12'h5dc, 12'h7d0})
    else $error("threshold not one of the coded values");
  // Settings come back disabled and shortest after each reset
  a_cfg_reset_vals: assert property ($fell(i_rst) |->
    !o_power_loss_restart_enable && o_power_loss_threshold_ms == 12'h1f4)
    else $error("power-loss settings wrong after reset");
  a_sda_reset_free: assert property ($fell(i_rst) |-> !o_sda_oe)
    else $error("sda held after reset");
  // Register writes land on a falling clock, so settings move while it is low
  a_en_moves_low: assert property ($changed(o_power_loss_restart_enable) |-> !i_scl)
    else $error("enable changed while scl high");
  a_thr_moves_low: assert property ($changed(o_power_loss_threshold_ms) |-> !i_scl)
    else $error("threshold changed while scl high");
  // Data may only change while the bus clock is low
  a_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("sda pulled while scl high");
  a_oe_steady_high: assert property (i_scl && $past(i_scl, 2) |-> $stable(o_sda_oe))
    else $error("sda drive moved while scl high");
endmodule

// file: sim/rtcus_top_test.sv
`timescale 1ns/1ps
module rtcus_top_test;
  import rtcus_pkg::*;
  localparam int SEC_P = 2000;
  logic i_mclk;
  logic i_rst;
  logic scl;
  logic host_low;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic en;
  logic [11:0] thr;
  logic [7:0] d;
  int n_errors;
  int check_count;
  int cyc;
  // Open-drain wire with pull-up
  assign sda = !(host_low || sda_oe);
  // Short counts keep the run brief
  rtcus_top #(.TRANSFER_CYCLES_P(20), .SECOND_CYCLES_P(SEC_P)) u_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_power_loss_restart_enable(en), .o_power_loss_threshold_ms(thr));
  rtcus_host u_host (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(a, v);
    chk({4'h0, v}, {4'h0, exp});
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    u_host.wr(8'hd0, a, v);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    i_rst = 1'b1;
    repeat (5) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    // Reset values and an unmapped offset
    rchk(ADDR_TIME_CTRL, 8'h00);
    rchk(ADDR_UPDATE_CTRL, 8'h02);
    rchk(ADDR_UPDATE_FLAGS, 8'h00);
    rchk(ADDR_POWER_LOSS_CONFIG, 8'h00);
    rchk(ADDR_MINUTE_FRACTION_COUNT, 8'h00);
    rchk(8'h10, 8'h00);
    chk({11'h0, en}, 12'h0);
    $display("Test reset done");
    // Every threshold code, reserved bits written high
    for (int c = 0; c < 4; c++) begin
      w(ADDR_POWER_LOSS_CONFIG, {c[0], 3'h7, c[1:0], 2'h3});
      rchk(ADDR_POWER_LOSS_CONFIG, {c[0], 3'h0, c[1:0], 2'h0});
      chk(thr, 12'(500 * (c + 1)));
      chk({11'h0, en}, {11'h0, c[0]});
    end
    // Foreign address draws no ack and changes nothing
    u_host.wr(8'hd2, ADDR_POWER_LOSS_CONFIG, 8'h00);
    chk(12'(u_host.nacks), 12'h3);
    rchk(ADDR_POWER_LOSS_CONFIG, 8'h8c);
    $display("Test power-loss done");
    // Buffered write, snapshot, flags kept until written to zero
    w(ADDR_UPDATE_CTRL, 8'h04);
    w(ADDR_MINUTE_FRACTION_COUNT, 8'haa);
    rchk(ADDR_MINUTE_FRACTION_COUNT, 8'h00);
    w(ADDR_UPDATE_CTRL, 8'h05);
    rchk(ADDR_UPDATE_CTRL, 8'h04);
    rchk(ADDR_UPDATE_FLAGS, 8'h01);
    rchk(ADDR_UPDATE_FLAGS, 8'h01);
    rchk(ADDR_MINUTE_FRACTION_COUNT, 8'h00);
    w(ADDR_UPDATE_CTRL, 8'h14);
    rchk(ADDR_UPDATE_CTRL, 8'h04);
    rchk(ADDR_UPDATE_FLAGS, 8'h03);
    rchk(ADDR_MINUTE_FRACTION_COUNT, 8'h2a);
    w(ADDR_UPDATE_FLAGS, 8'h02);
    rchk(ADDR_UPDATE_FLAGS, 8'h02);
    // Clear on read
    w(ADDR_UPDATE_CTRL, 8'h16);
    rchk(ADDR_UPDATE_FLAGS, 8'h02);
    rchk(ADDR_UPDATE_FLAGS, 8'h00);
    $display("Test buffers done");
    // Last second rolls over, then a BCD tens carry; one or two ticks pass, low bit free
    for (int m = 0; m < 3; m++) begin
      w(ADDR_TIME_CTRL, (m == 0) ? 8'h00 : 8'h01);
      w(ADDR_MINUTE_FRACTION_COUNT, (m == 0) ? 8'h3b : (m == 1) ? 8'h59 : 8'h29);
      w(ADDR_UPDATE_CTRL, 8'h01);
      repeat (SEC_P) @(posedge i_mclk);
      w(ADDR_UPDATE_CTRL, 8'h16);
      rchk(ADDR_UPDATE_FLAGS, 8'h03);
      u_host.rd(ADDR_MINUTE_FRACTION_COUNT, d);
      chk({4'h0, d & 8'hfe}, (m == 2) ? 12'h030 : 12'h000);
    end
    $display("Test rollover done");
    // Supply loss in mid-run brings settings and buffers back to reset
    @(posedge i_mclk);
    #1 i_rst = 1'b1;
    repeat (5) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    chk({11'h0, en}, 12'h0);
    chk(thr, 12'h1f4);
    rchk(ADDR_POWER_LOSS_CONFIG, 8'h00);
    rchk(ADDR_UPDATE_CTRL, 8'h02);
    rchk(ADDR_MINUTE_FRACTION_COUNT, 8'h00);
    $display("Test reset again done");
    give_verdict();
  end
endmodule
bind rtcus_top rtcus_top_checker u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_power_loss_restart_enable(o_power_loss_restart_enable),
  .o_power_loss_threshold_ms(o_power_loss_threshold_ms));
